/* pkg/c5cal_pkg.sv */
// Contract
// - The offset high register holds offset bits 23..8 over all 16 bits, read and write.
// - The offset low register holds offset bits 7..0 in its upper byte, read and write.
// - The gain high register holds gain bits 23..8 over all 16 bits, read and write.
// - The gain low register holds gain bits 7..0 in its upper byte, read and write.
// - The 24-bit gain is an unsigned fraction from zero to just below two, step 2/2^24.
// - The gain high register reads 8000h after reset, so the gain starts at unity.
// - Both offset registers and the gain low register read zero after reset.
// - The low byte of both low registers is read-only and always reads zero.
// - A read-only register at 3Eh reports the register map checksum; writes are ignored.
// - The checksum register reads 0000h right after reset.
`default_nettype none
package c5cal_pkg;
    localparam int C5CAL_AW = 6;
    localparam logic [5:0] C5CAL_OFS_HI_ADDR = 6'h23;
    localparam logic [5:0] C5CAL_OFS_LO_ADDR = 6'h24;
    localparam logic [5:0] C5CAL_GAIN_HI_ADDR = 6'h25;
    localparam logic [5:0] C5CAL_GAIN_LO_ADDR = 6'h26;
    localparam logic [5:0] C5CAL_CRC_ADDR = 6'h3e;
    localparam logic [5:0] C5CAL_RSVD_ADDR = 6'h3f;
    localparam logic [15:0] C5CAL_OFS_HI_RST = 16'h0000;
    localparam logic [7:0] C5CAL_OFS_LO_RST = 8'h00;
    localparam logic [15:0] C5CAL_GAIN_HI_RST = 16'h8000;
    localparam logic [7:0] C5CAL_GAIN_LO_RST = 8'h00;
    localparam logic [15:0] C5CAL_CRC_RST = 16'h0000;
    localparam logic [15:0] C5CAL_RSVD_RST = 16'h0000;
    localparam logic [7:0] C5CAL_RSVD_BYTE = 8'h00;
    localparam int C5CAL_LO_FIELD_LSB = 8;
    localparam int C5CAL_GAIN_FRAC_BITS = 23;
endpackage
`default_nettype wire

/* rtl/c5cal_word_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// One calibration word pair: 16-bit high register plus 8-bit field in the low register
module c5cal_word_reg
    import c5cal_pkg::*;
#(
    parameter logic [15:0] HI_RST = 16'h0000,
    parameter logic [7:0] LO_RST = 8'h00
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Write strobes and data
    input wire logic wr_hi_in,
    input wire logic wr_lo_in,
    input wire logic [15:0] wdata_in,
    // Stored views
    output logic [15:0] hi_out,
    output logic [15:0] lo_out,
    output logic [23:0] value_out
);
    logic [15:0] hi_q;
    logic [7:0] lo_q;

    // High word, full width writable
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hi_q <= HI_RST;
        end else if (wr_hi_in) begin
            hi_q <= wdata_in;
        end
    end

    // Only the upper byte of the low word is stored; the rest does not exist
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lo_q <= LO_RST;
        end else if (wr_lo_in) begin
            lo_q <= wdata_in[15:C5CAL_LO_FIELD_LSB];
        end
    end

    // Read views and the joined value
    assign hi_out = hi_q;
    assign lo_out = {lo_q, C5CAL_RSVD_BYTE};
    assign value_out = {hi_q, lo_q};
endmodule
`default_nettype wire

/* rtl/c5cal_map_crc.sv */
`timescale 1ns/1ps
`default_nettype none
// Register map checksum holder; the calculation itself lives elsewhere in the device
module c5cal_map_crc
    import c5cal_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Checksum update from the map checker
    input wire logic crc_valid_in,
    input wire logic [15:0] crc_value_in,
    // Held value
    output logic [15:0] crc_out
);
    logic [15:0] crc_q;

    // Only the checker updates it; the host port cannot reach this flop
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crc_q <= C5CAL_CRC_RST;
        end else if (crc_valid_in) begin
            crc_q <= crc_value_in;
        end
    end

    assign crc_out = crc_q;
endmodule
`default_nettype wire

/* rtl/c5cal_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Channel 5 calibration registers, map checksum and top reserved word
module c5cal_regs
    import c5cal_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Register access from the serial register interface
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_hit_out,
    // Checksum from the map checker
    input wire logic crc_valid_in,
    input wire logic [15:0] crc_value_in,
    // Calibration values toward the channel 5 datapath
    output logic [23:0] ch5_offset_out,
    output logic [23:0] ch5_gain_out,
    output logic rsvd_nonzero_out
);
    // Write strobes, one per host-writable register
    logic wr_ofs_hi;
    logic wr_ofs_lo;
    logic wr_gain_hi;
    logic wr_gain_lo;
    logic wr_rsvd;
    // Read views from the register pairs and the checksum holder
    logic [15:0] ofs_hi;
    logic [15:0] ofs_lo;
    logic [15:0] gain_hi;
    logic [15:0] gain_lo;
    logic [15:0] crc;
    // Joined 24-bit calibration values
    logic [23:0] ofs_val;
    logic [23:0] gain_val;
    // Reserved word and read path
    logic [15:0] rsvd_q;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic hit_d;

    // Address decode; the checksum address has no write strobe at all
    assign wr_ofs_hi = reg_wr_in && (reg_addr_in == C5CAL_OFS_HI_ADDR);
    assign wr_ofs_lo = reg_wr_in && (reg_addr_in == C5CAL_OFS_LO_ADDR);
    assign wr_gain_hi = reg_wr_in && (reg_addr_in == C5CAL_GAIN_HI_ADDR);
    assign wr_gain_lo = reg_wr_in && (reg_addr_in == C5CAL_GAIN_LO_ADDR);
    assign wr_rsvd = reg_wr_in && (reg_addr_in == C5CAL_RSVD_ADDR);

    c5cal_word_reg #(
        .HI_RST(C5CAL_OFS_HI_RST),
        .LO_RST(C5CAL_OFS_LO_RST)
    ) u_offset (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr_hi_in(wr_ofs_hi),
        .wr_lo_in(wr_ofs_lo),
        .wdata_in(reg_wdata_in),
        .hi_out(ofs_hi),
        .lo_out(ofs_lo),
        .value_out(ofs_val)
    );

    c5cal_word_reg #(
        .HI_RST(C5CAL_GAIN_HI_RST),
        .LO_RST(C5CAL_GAIN_LO_RST)
    ) u_gain (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr_hi_in(wr_gain_hi),
        .wr_lo_in(wr_gain_lo),
        .wdata_in(reg_wdata_in),
        .hi_out(gain_hi),
        .lo_out(gain_lo),
        .value_out(gain_val)
    );

    c5cal_map_crc u_crc (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .crc_valid_in(crc_valid_in),
        .crc_value_in(crc_value_in),
        .crc_out(crc)
    );

    // Reserved word is stored as written so a host slip stays visible
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rsvd_q <= C5CAL_RSVD_RST;
        end else if (wr_rsvd) begin
            rsvd_q <= reg_wdata_in;
        end
    end

    // Flag a nonzero write to the reserved word instead of trusting the host
    assign rsvd_nonzero_out = (rsvd_q != C5CAL_RSVD_RST);

    // Read mux; other addresses belong to neighbouring blocks and read zero here
    always_comb begin
        rdata_d = 16'h0000;
        hit_d = 1'b1;
        unique case (reg_addr_in)
            C5CAL_OFS_HI_ADDR: rdata_d = ofs_hi;
            C5CAL_OFS_LO_ADDR: rdata_d = ofs_lo;
            C5CAL_GAIN_HI_ADDR: rdata_d = gain_hi;
            C5CAL_GAIN_LO_ADDR: rdata_d = gain_lo;
            C5CAL_CRC_ADDR: rdata_d = crc;
            C5CAL_RSVD_ADDR: rdata_d = rsvd_q;
            default: hit_d = 1'b0;
        endcase
    end

    // Read data registered one cycle after the read strobe
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_in) begin
            rdata_q <= rdata_d;
        end
    end

    // Read data and decode hit toward the host
    assign reg_rdata_out = rdata_q;
    assign reg_hit_out = hit_d;

    // Offset is two's complement, gain is unsigned Q1.23 (unity at 800000h)
    assign ch5_offset_out = ofs_val;
    assign ch5_gain_out = gain_val;

    // Assertions; every check is paused while reset is held
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // A high offset write lands on the joined value one cycle later
    ofs_hi_write_a: assert property (
        wr_ofs_hi
        |=> ch5_offset_out[23:8] == $past(reg_wdata_in))
        else $error("offset high not stored");

    // Only the upper byte of a low offset write is kept
    ofs_lo_write_a: assert property (
        wr_ofs_lo
        |=> ch5_offset_out[7:0] == $past(reg_wdata_in[15:8]))
        else $error("offset low not stored");

    // A high gain write lands on the joined value one cycle later
    gain_hi_write_a: assert property (
        wr_gain_hi
        |=> ch5_gain_out[23:8] == $past(reg_wdata_in))
        else $error("gain high not stored");

    // Only the upper byte of a low gain write is kept
    gain_lo_write_a: assert property (
        wr_gain_lo
        |=> ch5_gain_out[7:0] == $past(reg_wdata_in[15:8]))
        else $error("gain low not stored");

    // Without its own strobe the offset high bits never move
    ofs_hi_hold_a: assert property (
        !wr_ofs_hi
        |=> $stable(ch5_offset_out[23:8]))
        else $error("offset high moved without write");

    // Without its own strobe the offset low bits never move
    ofs_lo_hold_a: assert property (
        !wr_ofs_lo
        |=> $stable(ch5_offset_out[7:0]))
        else $error("offset low moved without write");

    // Without its own strobe the gain high bits never move
    gain_hi_hold_a: assert property (
        !wr_gain_hi
        |=> $stable(ch5_gain_out[23:8]))
        else $error("gain high moved without write");

    // Without its own strobe the gain low bits never move
    gain_lo_hold_a: assert property (
        !wr_gain_lo
        |=> $stable(ch5_gain_out[7:0]))
        else $error("gain low moved without write");

    // Gain starts at unity, so an unconfigured channel passes samples unchanged
    gain_unity_a: assert property (
        $rose(arst_n_in)
        |-> ch5_gain_out == 24'h800000)
        else $error("gain not unity after reset");

    // Offset starts at zero
    ofs_reset_a: assert property (
        $rose(arst_n_in)
        |-> ch5_offset_out == 24'h000000)
        else $error("offset not zero after reset");

    // Reading the offset high word returns the value held at the read edge
    ofs_hi_read_a: assert property (
        reg_rd_in && reg_addr_in == C5CAL_OFS_HI_ADDR
        |=> reg_rdata_out == $past(ch5_offset_out[23:8]))
        else $error("offset high read wrong");

    // Reading the offset low word returns its byte above a zero byte
    ofs_lo_read_a: assert property (
        reg_rd_in && reg_addr_in == C5CAL_OFS_LO_ADDR
        |=> reg_rdata_out == {$past(ch5_offset_out[7:0]), 8'h00})
        else $error("offset low read wrong");

    // Reading the gain high word returns the value held at the read edge
    gain_hi_read_a: assert property (
        reg_rd_in && reg_addr_in == C5CAL_GAIN_HI_ADDR
        |=> reg_rdata_out == $past(ch5_gain_out[23:8]))
        else $error("gain high read wrong");

    // Reading the gain low word returns its byte above a zero byte
    gain_lo_read_a: assert property (
        reg_rd_in && reg_addr_in == C5CAL_GAIN_LO_ADDR
        |=> reg_rdata_out == {$past(ch5_gain_out[7:0]), 8'h00})
        else $error("gain low read wrong");

    // The reserved byte of either low word always reads zero
    low_byte_zero_a: assert property (
        reg_rd_in && (reg_addr_in == C5CAL_OFS_LO_ADDR || reg_addr_in == C5CAL_GAIN_LO_ADDR)
        |=> reg_rdata_out[7:0] == 8'h00)
        else $error("reserved byte not zero");

    // A host write to the checksum address is ignored
    crc_ro_a: assert property (
        reg_wr_in && reg_addr_in == C5CAL_CRC_ADDR && !crc_valid_in
        |=> $stable(crc))
        else $error("checksum changed by write");

    // Reading the checksum returns the value held at the read edge
    crc_read_a: assert property (
        reg_rd_in && reg_addr_in == C5CAL_CRC_ADDR
        |=> reg_rdata_out == $past(crc))
        else $error("checksum read wrong");

    // Only the map checker's load strobe moves the checksum
    crc_hold_a: assert property (
        !crc_valid_in
        |=> $stable(crc))
        else $error("checksum moved without load");

    // A load strobe takes the checker's value
    crc_load_a: assert property (
        crc_valid_in
        |=> crc == $past(crc_value_in))
        else $error("checksum not loaded");

    // Checksum starts at zero
    crc_reset_a: assert property (
        $rose(arst_n_in)
        |-> crc == 16'h0000)
        else $error("checksum not zero after reset");

    // A gain high then low write pair shows up joined on the datapath value
    join_value_a: assert property (
        wr_gain_hi ##1 !wr_gain_hi ##1 wr_gain_lo
        |=> ch5_gain_out == {$past(reg_wdata_in, 3), $past(reg_wdata_in[15:8])})
        else $error("gain join mismatch");

    // An offset high then low write pair shows up joined on the datapath value
    ofs_join_a: assert property (
        wr_ofs_hi ##1 !wr_ofs_hi ##1 wr_ofs_lo
        |=> ch5_offset_out == {$past(reg_wdata_in, 3), $past(reg_wdata_in[15:8])})
        else $error("offset join mismatch");

    // A legal zero write keeps the reserved word flag low
    rsvd_clear_a: assert property (
        wr_rsvd && reg_wdata_in == 16'h0000
        |=> !rsvd_nonzero_out)
        else $error("reserved flag after zero write");

    // Reserved word starts at zero, so the flag starts low
    rsvd_reset_a: assert property (
        $rose(arst_n_in)
        |-> !rsvd_nonzero_out)
        else $error("reserved flag high after reset");

    // Read data starts at zero
    rdata_reset_a: assert property (
        $rose(arst_n_in)
        |-> reg_rdata_out == 16'h0000)
        else $error("read data not zero after reset");

    // Read data stands until the next read strobe
    rdata_hold_a: assert property (
        !reg_rd_in
        |=> $stable(reg_rdata_out))
        else $error("read data moved without read");

    // Addresses outside this block read zero
    unmapped_zero_a: assert property (
        reg_rd_in && !reg_hit_out
        |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");

    // Main scenarios: paired writes, read after write, checksum load, reserved, unmapped
    gain_write_c: cover property (wr_gain_hi ##[1:4] wr_gain_lo);
    ofs_read_c: cover property (wr_ofs_lo ##1 reg_rd_in && reg_addr_in == C5CAL_OFS_LO_ADDR);
    crc_upd_c: cover property (crc_valid_in ##1 reg_rd_in && reg_addr_in == C5CAL_CRC_ADDR);
    rsvd_write_c: cover property (wr_rsvd);
    unmapped_rd_c: cover property (reg_rd_in && !reg_hit_out);
endmodule
`default_nettype wire

/* tb/c5cal_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port; one access per call, never back to back
module c5cal_host_model (
    // Clock
    input wire logic clk_in,
    // Register port toward the device
    output logic wr_out,
    output logic rd_out,
    output logic [5:0] addr_out,
    output logic [15:0] wdata_out,
    input wire logic [15:0] rdata_in
);
    // Idle port at time zero
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 6'h00;
        wdata_out = 16'h0000;
    end

    // Strobe raised just after an edge and held until the taking edge
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_in);
        #1;
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = (a == 6'h3f) ? 16'h0000 : d;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
    endtask

    // Read data is registered, so it is settled one step after the taking edge
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk_in);
        #1;
        rd_out = 1'b1;
        addr_out = a;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_in, arst_n_in, crc_valid_in, wr, rd, hit, rsvd_nz;
    logic [5:0] addr;
    logic [15:0] wdata, rdata, crc_value_in, rdat;
    logic [23:0] ofs, gain;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [5:0] ad [6] = '{6'h23, 6'h24, 6'h25, 6'h26, 6'h3e, 6'h3f};
    logic [15:0] rv [6] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] wv [6] = '{16'ha5c3, 16'h5aff, 16'hffff, 16'hff77, 16'hffff, 16'h0000};
    logic [15:0] ev [6] = '{16'ha5c3, 16'h5a00, 16'hffff, 16'hff00, 16'h0000, 16'h0000};

    c5cal_regs c5cal_regs_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_hit_out(hit), .crc_valid_in(crc_valid_in), .crc_value_in(crc_value_in),
        .ch5_offset_out(ofs), .ch5_gain_out(gain), .rsvd_nonzero_out(rsvd_nz));
    c5cal_host_model c5cal_host_model_inst (.clk_in(clk_in), .wr_out(wr), .rd_out(rd),
        .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata));

    // 250 MHz clock
    always #2 clk_in = ~clk_in;

    // Case equality so an unknown never passes
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic finish_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Run needs well under a hundred cycles; a hang is cut off here
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 1000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        clk_in = 1'b0;
        arst_n_in = 1'b0;
        crc_valid_in = 1'b0;
        crc_value_in = 16'h0000;
        repeat (8) @(posedge clk_in);
        #1;
        arst_n_in = 1'b1;
        chk("gain after reset", 24'h800000, gain);
        chk("offset after reset", 24'h000000, ofs);
        // Reset value of every register
        for (int i = 0; i < 6; i++) begin
            c5cal_host_model_inst.rd(ad[i], rdat);
            chk("reset read", {8'h00, rv[i]}, {8'h00, rdat});
        end
        // Write all, including the read-only checksum and reserved low bytes
        for (int i = 0; i < 6; i++)
            c5cal_host_model_inst.wr(ad[i], wv[i]);
        // An unmapped write must leave every stored value alone
        c5cal_host_model_inst.wr(6'h10, 16'h1234);
        for (int i = 0; i < 6; i++) begin
            c5cal_host_model_inst.rd(ad[i], rdat);
            chk("readback", {8'h00, ev[i]}, {8'h00, rdat});
        end
        chk("offset value", 24'ha5c35a, ofs);
        chk("gain value", 24'hffffff, gain);
        chk("reserved flag", 24'h000000, {23'h0, rsvd_nz});
        // Checksum moves only on its own load strobe
        @(posedge clk_in);
        #1;
        crc_valid_in = 1'b1;
        crc_value_in = 16'hbeef;
        @(posedge clk_in);
        #1;
        crc_valid_in = 1'b0;
        c5cal_host_model_inst.rd(6'h3e, rdat);
        chk("checksum", 24'h00beef, {8'h00, rdat});
        chk("checksum hit", 24'h000001, {23'h0, hit});
        c5cal_host_model_inst.rd(6'h10, rdat);
        chk("unmapped read", 24'h000000, {8'h00, rdat});
        chk("unmapped hit", 24'h000000, {23'h0, hit});
        // A second reset in mid-run must bring back every reset value
        arst_n_in = 1'b0;
        @(posedge clk_in);
        #1;
        arst_n_in = 1'b1;
        chk("gain after second reset", 24'h800000, gain);
        chk("offset after second reset", 24'h000000, ofs);
        chk("flag after second reset", 24'h000000, {23'h0, rsvd_nz});
        c5cal_host_model_inst.rd(6'h3e, rdat);
        chk("checksum after second reset", 24'h000000, {8'h00, rdat});
        finish_test();
    end
endmodule
`default_nettype wire
